// ---- tb/sccf_port_chk.sv ----
/* port checker of sccf_port.
   assumes it is bound to sccf_port and sees only its ports. */
`timescale 1ns/100ps
`include "sccf_defines.svh"
module sccf_port_chk
  import sccf_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire sccf_pkg::sccf_bus_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_miso,
  input wire logic i_sel,
  input wire sccf_pkg::sccf_pins_t o_pins,
  input wire logic o_gpio_sel,
  input wire logic o_irq
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic slv;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  assign slv = c1_q[6] && !c1_q[4];
  // shadow of what software wrote
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      c1_q <= `SCCF_CTRL1_RESET;
      c2_q <= `SCCF_CTRL2_RESET;
    end else if (i_bus.wr && i_bus.addr == `SCCF_OFF_CTRL1) begin
      c1_q <= i_bus.wdata;
    end else if (i_bus.wr && i_bus.addr == `SCCF_OFF_CTRL2) begin
      c2_q <= i_bus.wdata;
    end
  end
  property p_rd_idle;
    !i_bus.rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_c2_read;
    i_bus.rd && i_bus.addr == `SCCF_OFF_CTRL2 |=> o_rdata == (c2_q & `SCCF_C2_MASK);
  endproperty
  a_c2_read: assert property (p_c2_read) else $error("control two read wrong");
  property p_off_pins;
    !c1_q[6] |-> !(o_pins.sclk_oe || o_pins.mosi_oe || o_pins.miso_oe || o_pins.sel_oe);
  endproperty
  a_off_pins: assert property (p_off_pins) else $error("pin driven while off");
  property p_gpio;
    c1_q[6] |-> o_gpio_sel == (c1_q[4] && !c2_q[4]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("select pin function wrong");
  property p_slave_pins;
    slv |-> !o_pins.sclk_oe && !o_pins.mosi_oe && !o_pins.sel_oe;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave drives master pins");
  property p_idle_level;
    o_pins.sclk_oe && o_pins.sel_oe && o_pins.sel_o |-> o_pins.sclk_o == c1_q[3];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong");
  property p_sel_lead;
    $fell(o_pins.sel_o) && o_pins.sel_oe |-> (o_pins.sclk_o == c1_q[3]) [*4];
  endproperty
  a_sel_lead: assert property (p_sel_lead) else $error("select lead too short");
  property p_slave_drive;
    (slv && c1_q[2] && !i_sel) [*4] |-> o_pins.miso_oe;
  endproperty
  a_slave_drive: assert property (p_slave_drive) else $error("slave output not driven");
endmodule

bind sccf_port sccf_port_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(i_bus),
  .o_rdata(o_rdata), .i_sclk(i_sclk), .i_mosi(i_mosi), .i_miso(i_miso), .i_sel(i_sel),
  .o_pins(o_pins), .o_gpio_sel(o_gpio_sel), .o_irq(o_irq));

// ---- tb/sccf_slave_model.sv ----
/* behavioural external serial slave.
   assumes the bench resolves clock, data and select levels. */
`timescale 1ns/100ps
module sccf_slave_model (
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_sel,
  input wire logic i_clock_polarity,
  input wire logic i_clock_phase,
  input wire logic i_lsb,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  logic ck;
  int n;
  assign ck = i_sclk ^ i_clock_polarity;
  initial o_miso = 1'b0;
  task automatic put();
    if (n < 8) o_miso = i_lsb ? i_tx[n] : i_tx[7 - n];
  endtask
  task automatic smp();
    if (n < 8) o_rx[i_lsb ? n : 7 - n] = i_mosi;
    n++;
  endtask
  always @(negedge i_sel) begin
    n = 0;
    if (!i_clock_phase) put();
  end
  // a released line must not keep its last level
  always @(posedge i_sel) o_miso = ~o_miso;
  always @(posedge ck) if (!i_sel) begin
    if (i_clock_phase) put();
    else smp();
  end
  always @(negedge ck) if (!i_sel) begin
    if (i_clock_phase) smp();
    else put();
  end
endmodule

// ---- tb/tb_top.sv ----
/* self-checking bench of sccf_port with a slave model.
   assumes a 50 ns core clock and a 400 ns serial clock. */
`timescale 1ns/100ps
`include "sccf_defines.svh"
module tb_top;
  import sccf_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  sccf_bus_t i_bus = '0;
  logic [7:0] o_rdata;
  sccf_pins_t o_pins;
  logic o_gpio_sel;
  logic o_irq;
  logic m_sclk = 1'b0;
  logic m_mosi = 1'b0;
  logic m_sel = 1'b1;
  logic s_miso;
  logic [7:0] s_rx;
  logic [7:0] s_tx = 8'h00;
  logic [7:0] c1 = 8'h00;
  logic [7:0] v;
  logic [7:0] q;
  int err_count = 0;
  int check_count = 0;
  wire sclk_w = o_pins.sclk_oe ? o_pins.sclk_o : m_sclk;
  wire mosi_w = o_pins.mosi_oe ? o_pins.mosi_o : m_mosi;
  wire miso_w = o_pins.miso_oe ? o_pins.miso_o : s_miso;
  wire sel_w = o_pins.sel_oe ? o_pins.sel_o : m_sel;
  // control one, byte sent, byte the slave returns
  logic [7:0] rows [8][3] = '{'{8'h52, 8'ha5, 8'h3c}, '{8'h53, 8'h01, 8'h80}, '{8'h56, 8'h7e, 8'hc3},
    '{8'h57, 8'h80, 8'h01}, '{8'h5a, 8'hff, 8'h00}, '{8'h5b, 8'h00, 8'hff}, '{8'h5e, 8'h69, 8'h96},
    '{8'h5f, 8'hc8, 8'h13}};
  sccf_port dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_sclk(sclk_w), .i_mosi(mosi_w), .i_miso(miso_w), .i_sel(sel_w), .o_pins(o_pins),
    .o_gpio_sel(o_gpio_sel), .o_irq(o_irq));
  sccf_slave_model u_slave (.i_sclk(sclk_w), .i_mosi(mosi_w), .i_sel(sel_w), .i_clock_polarity(c1[3]),
    .i_clock_phase(c1[2]), .i_lsb(c1[0]), .i_tx(s_tx), .o_miso(s_miso), .o_rx(s_rx));
  always #25 i_clock = ~i_clock;
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_bus <= {a, d, 2'b10};
    @(posedge i_clock);
    i_bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge i_clock);
    i_bus <= {a, 8'h00, 2'b01};
    @(posedge i_clock);
    i_bus <= '0;
    @(negedge i_clock);
    v = o_rdata;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic done_wait();
    v = 8'h00;
    for (int k = 0; k < 100 && v[0] !== 1'b1; k++) rd(`SCCF_OFF_STATUS);
    chk(v & 8'h01, 8'h01, "done");
  endtask
  // plays master against the port in slave mode, msb first
  task automatic mbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      m_sclk <= 1'b1;
      m_mosi <= b[i];
      repeat (4) @(posedge i_clock);
      q[i] = miso_w;
      m_sclk <= 1'b0;
      repeat (4) @(posedge i_clock);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    wr(`SCCF_OFF_IRQ_EN, 8'h01);
    wr(`SCCF_OFF_CTRL1, 8'h44);
    wr(`SCCF_OFF_CTRL2, 8'h10);
    foreach (rows[r]) begin
      c1 = rows[r][0];
      s_tx = rows[r][2];
      wr(`SCCF_OFF_CTRL1, c1);
      wr(`SCCF_OFF_DATA, rows[r][1]);
      done_wait();
      chk({7'h00, o_irq}, 8'h01, "irq set");
      chk(s_rx, rows[r][1], "slave got");
      rd(`SCCF_OFF_DATA);
      chk(v, rows[r][2], "master got");
      wr(`SCCF_OFF_IRQ_CLR, 8'h01);
      rd(`SCCF_OFF_STATUS);
      chk({7'h00, o_irq}, 8'h00, "irq clear");
    end
    wr(`SCCF_OFF_IRQ_EN, 8'h00);
    wr(`SCCF_OFF_DATA, 8'h81);
    done_wait();
    chk({7'h00, o_irq}, 8'h00, "irq masked");
    wr(`SCCF_OFF_IRQ_CLR, 8'h01);
    wr(`SCCF_OFF_CTRL2, 8'h00);
    wr(`SCCF_OFF_CTRL1, 8'h50);
    @(negedge i_clock);
    chk({6'h00, o_gpio_sel, o_pins.sel_oe}, 8'h02, "gpio select");
    wr(`SCCF_OFF_CTRL2, 8'h10);
    @(posedge i_clock);
    m_sel <= 1'b0;
    repeat (6) @(posedge i_clock);
    rd(`SCCF_OFF_STATUS);
    chk(v & 8'h02, 8'h02, "fault flag");
    rd(`SCCF_OFF_CTRL1);
    chk(v & 8'h10, 8'h00, "master bit");
    @(posedge i_clock);
    m_sel <= 1'b1;
    wr(`SCCF_OFF_IRQ_CLR, 8'h03);
    wr(`SCCF_OFF_CTRL1, 8'h44);
    wr(`SCCF_OFF_DATA, 8'h96);
    @(posedge i_clock);
    m_sel <= 1'b0;
    repeat (4) @(posedge i_clock);
    chk({7'h00, o_pins.miso_oe}, 8'h01, "slave drive");
    mbyte(8'h3c);
    chk(q, 8'h96, "slave out");
    mbyte(8'hc3);
    m_sel <= 1'b1;
    rd(`SCCF_OFF_DATA);
    chk(v, 8'hc3, "slave shifter");
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    chk({4'h0, o_pins.sclk_oe, o_pins.mosi_oe, o_pins.miso_oe, o_pins.sel_oe}, 8'h00, "oe");
    rd(`SCCF_OFF_CTRL1);
    chk(v, `SCCF_CTRL1_RESET, "ctrl1 reset");
    rd(`SCCF_OFF_DIV);
    chk(v, `SCCF_DIV_RESET, "div reset");
    rd(3'h7);
    chk(v, 8'h00, "unmapped");
    wr(`SCCF_OFF_CTRL2, 8'hff);
    rd(`SCCF_OFF_CTRL2);
    chk(v, 8'h1b, "ctrl2 read");
    close_out();
  end
endmodule

// ---- verilog/sccf_defines.svh ----
/*
  constants of the serial port control and clock-format block: register
  offsets, control bit positions, reset values and timing counts.
  assumes a 20 MHz core clock and an 8-bit register port.
*/
`ifndef SCCF_DEFINES_SVH
`define SCCF_DEFINES_SVH

`define SCCF_OFF_CTRL1 3'h0
`define SCCF_OFF_CTRL2 3'h1
`define SCCF_OFF_DATA 3'h2
`define SCCF_OFF_STATUS 3'h3
`define SCCF_OFF_IRQ_EN 3'h4
`define SCCF_OFF_IRQ_CLR 3'h5
`define SCCF_OFF_DIV 3'h6

`define SCCF_C1_PORT_ENABLE 6
`define SCCF_C1_MASTER_SELECT 4
`define SCCF_C1_CLOCK_POLARITY 3
`define SCCF_C1_CLOCK_PHASE 2
`define SCCF_C1_SELECT_OUTPUT_ENABLE 1
`define SCCF_C1_LOW_BIT_FIRST 0
`define SCCF_C2_MODE_FAULT_ENABLE 4
`define SCCF_C2_MASK 8'h1b

`define SCCF_ST_DONE 0
`define SCCF_ST_MODE_FAULT 1

`define SCCF_CTRL1_RESET 8'h04
`define SCCF_CTRL2_RESET 8'h00
`define SCCF_DIV_RESET 8'h03
`define SCCF_BITS 4'h8

`endif

// ---- verilog/sccf_pkg.sv ----
/*
  types of the serial port control and clock-format block.
  assumes sccf_defines.svh is included before use of the constants.
*/
package sccf_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sccf_bus_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic sel_o;
    logic sel_oe;
  } sccf_pins_t;

  typedef enum logic [1:0] {SCCF_IDLE, SCCF_LEAD, SCCF_XFER, SCCF_TAIL} sccf_state_t;
endpackage

// ---- verilog/sccf_port.sv ----
/*
  control and clock-format logic of a byte-wide serial peripheral port:
  master/slave operation, clock polarity and phase, bit order, select pin
  function and mode fault, with a small register port and interrupt.
  assumes pins are synchronised here; pin levels are resolved outside.
*/
// Notes on behaviour
// (R1) master_select low makes the port a slave and high makes it a master.
// (R2) clock_polarity 0 idles the clock low, 1 inverts it so it idles high.
// (R3) clock_phase 0 puts the first edge mid bit one, 1 puts it at the start of bit one.
// (R4) low_bit_first clear sends the high bit first, set sends the low bit first.
// (R5) in master mode the select pin is plain I/O, a fault input or an auto output by the enable bits; slave uses it as input.
// (R6) bits 7, 6, 5 and 2 of the second control register read as zero.
// (R7) software should not clear port_enable in the same write that changes clock_phase.
// (R8) the master auto select goes low half a clock period before the transfer and high after bit eight.
// (R9) with clock_phase 1 a selected slave drives its data output at once, valid from the first edge.
// (R10) with clock_phase 1 the first edge shifts out, the second samples and the third shifts in and presents the next bit.
// (R11) with clock_phase 1 a slave takes back-to-back bytes with select held low.
// (R12) with clock_phase 0 bit one starts at select low and bit eight ends at the last clock edge.
// (R13) a low fault input in master mode sets a mode fault flag and returns the port to slave.
// (R14) with port_enable clear the shifter idles and no pin is driven.
`timescale 1ns/100ps
`include "sccf_defines.svh"
module sccf_port
  import sccf_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire sccf_pkg::sccf_bus_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_miso,
  input wire logic i_sel,
  output sccf_pkg::sccf_pins_t o_pins,
  output logic o_gpio_sel,
  output logic o_irq
);
  import sccf_pkg::*;

  logic [7:0] ctrl1_q, ctrl2_q, div_q, tx_q, rx_q, shift_q, status_q, irq_en_q;
  logic [2:0] sclk_s_q, sel_s_q;
  logic [1:0] mosi_s_q, miso_s_q;
  logic [7:0] cnt_q;
  logic [3:0] edges_q;
  logic [3:0] s_bits_q;
  logic sample_q, sclk_q, tx_pend_q;
  sccf_state_t state_q;

  function automatic logic wr_at(input sccf_bus_t b, input logic [2:0] a);
    return b.wr && b.addr == a;
  endfunction

  wire logic en = ctrl1_q[`SCCF_C1_PORT_ENABLE];
  wire logic master_select = ctrl1_q[`SCCF_C1_MASTER_SELECT];
  wire logic clock_polarity = ctrl1_q[`SCCF_C1_CLOCK_POLARITY];
  wire logic clock_phase = ctrl1_q[`SCCF_C1_CLOCK_PHASE];
  wire logic select_output_enable = ctrl1_q[`SCCF_C1_SELECT_OUTPUT_ENABLE];
  wire logic lsbf = ctrl1_q[`SCCF_C1_LOW_BIT_FIRST];
  wire logic mode_fault_enable = ctrl2_q[`SCCF_C2_MODE_FAULT_ENABLE];

  // synchronisers: first stage only feeds second stage
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sclk_s_q <= 3'h0;
      sel_s_q <= 3'h7;
      mosi_s_q <= 2'h0;
      miso_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], i_sclk};
      sel_s_q <= {sel_s_q[1:0], i_sel};
      mosi_s_q <= {mosi_s_q[0], i_mosi};
      miso_s_q <= {miso_s_q[0], i_miso};
    end
  end

  // slave clock is inverted by polarity so a leading edge is always a rise
  wire logic s_clk_now = sclk_s_q[1] ^ clock_polarity; // R2
  wire logic s_clk_old = sclk_s_q[2] ^ clock_polarity;
  wire logic s_lead = s_clk_now && !s_clk_old;
  wire logic s_trail = !s_clk_now && s_clk_old;
  wire logic sel_low = !sel_s_q[1];
  wire logic sel_fall = !sel_s_q[1] && sel_s_q[2];
  wire logic fault_in = master_select && mode_fault_enable && !select_output_enable && sel_low; // R5 R13
  wire logic slave_act = en && !master_select && sel_low;
  wire logic in_bit = master_select ? miso_s_q[1] : mosi_s_q[1];
  wire logic out_bit = lsbf ? shift_q[0] : shift_q[7]; // R4
  wire logic tick = (cnt_q == div_q);
  wire logic m_busy = state_q != SCCF_IDLE;

  // control registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl1_q <= `SCCF_CTRL1_RESET;
      ctrl2_q <= `SCCF_CTRL2_RESET;
      div_q <= `SCCF_DIV_RESET;
      irq_en_q <= 8'h00;
    end else begin
      if (wr_at(i_bus, `SCCF_OFF_CTRL1)) begin
        ctrl1_q <= i_bus.wdata; // R1
      end else if (fault_in) begin
        ctrl1_q[`SCCF_C1_MASTER_SELECT] <= 1'b0; // R13
      end
      if (wr_at(i_bus, `SCCF_OFF_CTRL2)) begin
        ctrl2_q <= i_bus.wdata & `SCCF_C2_MASK; // R6
      end
      if (wr_at(i_bus, `SCCF_OFF_DIV)) begin
        div_q <= i_bus.wdata;
      end
      if (wr_at(i_bus, `SCCF_OFF_IRQ_EN)) begin
        irq_en_q <= i_bus.wdata;
      end
    end
  end

  // transmit holding register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tx_q <= 8'h00;
      tx_pend_q <= 1'b0;
    end else if (wr_at(i_bus, `SCCF_OFF_DATA)) begin
      tx_q <= i_bus.wdata;
      tx_pend_q <= 1'b1;
    end else if (!en || (master_select && state_q == SCCF_IDLE && tx_pend_q)) begin
      tx_pend_q <= 1'b0;
    end
  end

  // master sequencer: half-period ticks from the divider
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !en || !master_select) begin
      state_q <= SCCF_IDLE;
      cnt_q <= 8'h00;
      edges_q <= 4'h0;
      sclk_q <= 1'b0;
    end else begin
      cnt_q <= (tick || !m_busy) ? 8'h00 : cnt_q + 8'h01;
      unique case (state_q)
        SCCF_IDLE: begin
          edges_q <= 4'h0;
          if (tx_pend_q) begin
            state_q <= SCCF_LEAD;
          end
        end
        SCCF_LEAD: begin
          if (tick) begin
            state_q <= SCCF_XFER; // R8
            if (clock_phase) begin
              sclk_q <= 1'b1; // R3
              edges_q <= 4'h1;
            end
          end
        end
        SCCF_XFER: begin
          // sixteen edges in all; phase 1 has already made the first one on leaving the lead
          if (tick) begin
            sclk_q <= !sclk_q; // R3
            edges_q <= edges_q + 4'h1;
            if (edges_q == 4'hf) begin
              state_q <= SCCF_TAIL; // R12
            end
          end
        end
        SCCF_TAIL: begin
          if (tick) begin
            state_q <= SCCF_IDLE; // R8
          end
        end
      endcase
    end
  end

  // master edges: a rise of sclk_q is a leading edge
  wire logic m_edge = master_select && state_q == SCCF_XFER && tick;
  wire logic m_lead = m_edge && !sclk_q;
  wire logic m_trail = m_edge && sclk_q;
  wire logic lead_e = master_select ? m_lead : (slave_act && s_lead);
  wire logic trail_e = master_select ? m_trail : (slave_act && s_trail);
  // phase 0 samples on leading edge, phase 1 on trailing edge
  wire logic samp_e = clock_phase ? trail_e : lead_e; // R10
  wire logic shft_e = clock_phase ? lead_e : trail_e;

  // shifter: bit is sampled, then moved in on the next shift edge
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !en) begin
      shift_q <= 8'h00; // R14
      sample_q <= 1'b0;
      rx_q <= 8'h00;
    end else begin
      if (samp_e) begin
        sample_q <= in_bit; // R10
      end
      if (master_select && state_q == SCCF_IDLE && tx_pend_q) begin
        shift_q <= tx_q;
      end else if (!master_select && sel_fall) begin
        shift_q <= tx_q; // R9 R12
      end else if (!master_select && clock_phase && samp_e && s_bits_q == `SCCF_BITS - 4'h1) begin
        // phase 1 slave has no shift edge after its last sample, so the byte closes here
        shift_q <= lsbf ? {in_bit, shift_q[7:1]} : {shift_q[6:0], in_bit}; // R11
      end else if (shft_e && !(clock_phase && !master_select && s_bits_q == 4'h0)) begin
        // the first phase 1 edge of a slave byte only presents the bit already loaded
        shift_q <= lsbf ? {sample_q, shift_q[7:1]} : {shift_q[6:0], sample_q}; // R4 R10
      end
      if (master_select && state_q == SCCF_TAIL && tick) begin
        // phase 0 has shifted its eighth bit on the last edge, phase 1 still holds it as a sample
        if (!clock_phase) begin
          rx_q <= shift_q;
        end else begin
          rx_q <= lsbf ? {sample_q, shift_q[7:1]} : {shift_q[6:0], sample_q};
        end
      end
    end
  end

  // slave byte count for done flag, restarts per select or per eight bits
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !en || master_select || !sel_low) begin
      s_bits_q <= 4'h0;
    end else if (samp_e) begin
      s_bits_q <= (s_bits_q == `SCCF_BITS - 4'h1) ? 4'h0 : s_bits_q + 4'h1; // R11 R12
    end
  end
  wire logic s_done = samp_e && !master_select && s_bits_q == `SCCF_BITS - 4'h1;
  wire logic m_done = master_select && state_q == SCCF_TAIL && tick;

  // sticky status, set wins over clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      status_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if ((i == `SCCF_ST_DONE && (m_done || s_done)) || (i == `SCCF_ST_MODE_FAULT && fault_in)) begin
          status_q[i] <= 1'b1; // R13
        end else if (wr_at(i_bus, `SCCF_OFF_IRQ_CLR) && i_bus.wdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        `SCCF_OFF_CTRL1: o_rdata <= ctrl1_q;
        `SCCF_OFF_CTRL2: o_rdata <= ctrl2_q & `SCCF_C2_MASK; // R6
        `SCCF_OFF_DATA: o_rdata <= master_select ? rx_q : shift_q;
        `SCCF_OFF_STATUS: o_rdata <= status_q;
        `SCCF_OFF_IRQ_EN: o_rdata <= irq_en_q;
        `SCCF_OFF_DIV: o_rdata <= div_q;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign o_irq = |(status_q & irq_en_q);

  // pins
  always_comb begin
    o_pins = '0;
    o_gpio_sel = en && master_select && !mode_fault_enable; // R5
    if (en && master_select) begin
      o_pins.sclk_oe = 1'b1;
      o_pins.sclk_o = sclk_q ^ clock_polarity; // R2
      o_pins.mosi_oe = 1'b1;
      o_pins.mosi_o = out_bit;
      o_pins.sel_oe = mode_fault_enable && select_output_enable; // R5
      o_pins.sel_o = !(m_busy); // R8
    end else if (slave_act) begin
      o_pins.miso_oe = 1'b1; // R9
      o_pins.miso_o = out_bit;
    end
  end
endmodule
